// *** hw/rfcmd_core.v ***
// Command interpreter of the radio transceiver serial command port
// Summary of operation
// RULE1: Controller drops command select to 0 before the first byte of each command.
// RULE2: Controller sends commands by writing bytes into the SPI master data port.
// RULE3: Status byte shifts out while the command byte shifts in.
// RULE4: Each command opens with one command byte, most significant bit first.
// RULE5: Data bytes go least significant byte first, each byte MSB first.
// RULE6: 000A AAAA reads register reg_index, returning 1 to 5 bytes.
// RULE7: 001A AAAA writes 1 to 5 bytes, only in power-down or standby.
// RULE8: 0110 0001 reads 1 to 32 received bytes from 0, then drops payload.
// RULE9: 1010 0000 takes 1 to 32 transmit payload bytes starting at byte 0.
// RULE10: 1110 0001 empties the transmit FIFO, no data bytes.
// RULE11: 1110 0010 empties the receive FIFO, no data bytes.
// RULE12: Controller avoids receive flush while an acknowledge is being sent.
// RULE13: 1110 0011 repeats last payload until payload write or transmit flush.
// RULE14: Controller must not toggle payload repeat during a transmission.
// RULE15: 0110 0000 returns one byte, width of head received payload.
// RULE16: 1010 1PPP takes 1 to 32 acknowledge payload bytes for pipe_index.
// RULE17: Pipe 000 to 101, three acknowledge payloads pending at most, FIFO order.
// RULE18: 1011 0000 takes a payload sent without automatic acknowledge once.
// RULE19: 1111 1111 does nothing except return the status byte.
// RULE20: Command select is bit 1 of radio_control_reg at 0xE8, active low.
// RULE21: Controller raises command select again after the last data byte.
`include "rfcmd_defs.vh"

module rfcmd_core (
  input wire clk_i,
  input wire resetn_i,
  input wire sck_i,
  input wire mosi_i,
  input wire radio_control_csn_n_i,
  output wire miso_o,
  input wire [7:0] status_i,
  input wire standby_i,
  input wire tx_full_i,
  input wire [7:0] reg_rd_data_i,
  input wire [7:0] rx_rd_data_i,
  input wire [5:0] rx_head_width_i,
  input wire ack_sent_i,
  output reg [4:0] reg_index_o,
  output reg [2:0] reg_byte_o,
  output reg reg_wr_o,
  output reg [7:0] reg_wr_data_o,
  output reg [4:0] rx_rd_index_o,
  output reg rx_pop_o,
  output reg rx_flush_o,
  output reg tx_wr_o,
  output reg [4:0] tx_wr_index_o,
  output reg [7:0] tx_wr_data_o,
  output reg tx_commit_o,
  output reg [1:0] tx_commit_kind_o,
  output reg [2:0] tx_commit_pipe_o,
  output reg [5:0] tx_commit_len_o,
  output reg tx_flush_o,
  output reg tx_reuse_o,
  output reg [1:0] ack_pending_o
);

  // --------------------------------------------------------------------------
  // Command classes (one-hot) and states
  // --------------------------------------------------------------------------
  localparam C_RREG = 0;
  localparam C_WREG = 1;
  localparam C_RXPL = 2;
  localparam C_TXPL = 3;
  localparam C_FTX = 4;
  localparam C_FRX = 5;
  localparam C_REUSE = 6;
  localparam C_WID = 7;
  localparam C_ACK = 8;
  localparam C_NOACK = 9;
  localparam C_IDLE = 10;
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_CMD = 3'b010;
  localparam [2:0] S_DATA = 3'b100;

  // Unknown words decode to nothing and act like the idle command
  function [10:0] decode;
    input [7:0] b;
    begin
      decode = 11'h000;
      if (b[7:5] == `RFCMD_RD_REG_PFX)
        decode[C_RREG] = 1'b1; // RULE6
      else if (b[7:5] == `RFCMD_WR_REG_PFX)
        decode[C_WREG] = 1'b1; // RULE7
      else if (b[7:3] == `RFCMD_WR_ACK_PFX)
        decode[C_ACK] = 1'b1; // RULE16
      else
      begin
        case (b)
          `RFCMD_RD_RX_PL: decode[C_RXPL] = 1'b1; // RULE8
          `RFCMD_WR_TX_PL: decode[C_TXPL] = 1'b1; // RULE9
          `RFCMD_FLUSH_TX: decode[C_FTX] = 1'b1; // RULE10
          `RFCMD_FLUSH_RX: decode[C_FRX] = 1'b1; // RULE11
          `RFCMD_REPEAT_LAST: decode[C_REUSE] = 1'b1; // RULE13
          `RFCMD_RD_HEAD_WIDTH: decode[C_WID] = 1'b1; // RULE15
          `RFCMD_WR_UNACKED: decode[C_NOACK] = 1'b1; // RULE18
          `RFCMD_IDLE: decode[C_IDLE] = 1'b1; // RULE19
          default: decode = 11'h000;
        endcase
      end
    end
  endfunction

  reg [2:0] state_reg;
  reg [10:0] cmd_reg;
  reg [2:0] pipe_reg;
  reg [5:0] idx_reg;
  reg accept_reg;
  reg [7:0] out_byte_reg;
  reg [7:0] out_byte_next;
  reg [10:0] dec;
  wire frame_start;
  wire frame_end;
  wire byte_valid;
  wire [7:0] rx_byte;
  wire [1:0] ack_total;

  // --------------------------------------------------------------------------
  // Serial byte shifter
  // --------------------------------------------------------------------------
  rfcmd_shifter u_shifter (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sck_i(sck_i),
    .mosi_i(mosi_i),
    .csn_n_i(radio_control_csn_n_i), // RULE20
    .status_i(status_i),
    .tx_byte_i(out_byte_reg),
    .frame_start_o(frame_start),
    .frame_end_o(frame_end),
    .byte_valid_o(byte_valid),
    .rx_byte_o(rx_byte),
    .miso_o(miso_o)
  );

  // --------------------------------------------------------------------------
  // Next byte to return; read addresses follow the data byte index
  // --------------------------------------------------------------------------
  always @*
  begin
    dec = decode(rx_byte);
    out_byte_next = 8'h00;
    if (state_reg == S_DATA)
    begin
      if (cmd_reg[C_RREG] && idx_reg < `RFCMD_REG_MAX_BYTES)
        out_byte_next = reg_rd_data_i; // RULE6
      else if (cmd_reg[C_RXPL] && idx_reg < `RFCMD_PL_MAX_BYTES)
        out_byte_next = rx_rd_data_i; // RULE8
      else if (cmd_reg[C_WID] && idx_reg == 6'h00)
        out_byte_next = {2'h0, rx_head_width_i}; // RULE15
    end
  end

  // Registered so the shifter sees a stable byte at the next falling edge
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      out_byte_reg <= 8'h00;
      reg_byte_o <= 3'h0;
      rx_rd_index_o <= 5'h00;
    end
    else
    begin
      out_byte_reg <= out_byte_next;
      reg_byte_o <= idx_reg[2:0]; // RULE5
      rx_rd_index_o <= idx_reg[4:0];
    end
  end

  // Pending acknowledge payloads; a send and a commit in one cycle cancel
  assign ack_total = ack_pending_o + {1'b0, tx_commit_o && tx_commit_kind_o == `RFCMD_KIND_ACK};

  // --------------------------------------------------------------------------
  // Command sequencing
  // --------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= S_IDLE;
      cmd_reg <= 11'h000;
      pipe_reg <= 3'h0;
      idx_reg <= 6'h00;
      accept_reg <= 1'b0;
      reg_index_o <= 5'h00;
      reg_wr_o <= 1'b0;
      reg_wr_data_o <= 8'h00;
      rx_pop_o <= 1'b0;
      rx_flush_o <= 1'b0;
      tx_wr_o <= 1'b0;
      tx_wr_index_o <= 5'h00;
      tx_wr_data_o <= 8'h00;
      tx_commit_o <= 1'b0;
      tx_commit_kind_o <= `RFCMD_KIND_NORMAL;
      tx_commit_pipe_o <= 3'h0;
      tx_commit_len_o <= 6'h00;
      tx_flush_o <= 1'b0;
      tx_reuse_o <= 1'b0;
      ack_pending_o <= 2'h0;
    end
    else
    begin
      reg_wr_o <= 1'b0;
      rx_pop_o <= 1'b0;
      rx_flush_o <= 1'b0;
      tx_wr_o <= 1'b0;
      tx_commit_o <= 1'b0;
      tx_flush_o <= 1'b0;
      ack_pending_o <= (ack_sent_i && ack_total != 2'h0) ? ack_total - 2'h1 : ack_total; // RULE17
      case (state_reg)
        S_IDLE:
        begin
          if (frame_start)
            state_reg <= S_CMD; // RULE1
        end
        S_CMD:
        begin
          if (frame_end)
            state_reg <= S_IDLE;
          else if (byte_valid)
          begin
            // Command byte taken; single-byte commands act at once
            state_reg <= S_DATA; // RULE4
            cmd_reg <= dec;
            pipe_reg <= rx_byte[2:0];
            reg_index_o <= rx_byte[4:0];
            idx_reg <= 6'h00;
            accept_reg <= (dec[C_WREG] & standby_i) // RULE7
              | ((dec[C_TXPL] | dec[C_NOACK]) & ~tx_full_i)
              | (dec[C_ACK] & ~tx_full_i & (rx_byte[2:0] <= `RFCMD_ACK_PIPE_MAX) // RULE17
                 & (ack_pending_o < `RFCMD_ACK_MAX_PENDING));
            if (dec[C_FTX])
              tx_flush_o <= 1'b1; // RULE10
            if (dec[C_FRX])
              rx_flush_o <= 1'b1; // RULE11
            if (dec[C_REUSE])
              tx_reuse_o <= 1'b1; // RULE13
            else if (dec[C_FTX] | dec[C_TXPL])
              tx_reuse_o <= 1'b0; // RULE13
          end
        end
        S_DATA:
        begin
          if (frame_end)
          begin
            state_reg <= S_IDLE;
            // Reading any byte of the head payload removes it
            if (cmd_reg[C_RXPL] && idx_reg != 6'h00)
              rx_pop_o <= 1'b1; // RULE8
            if ((cmd_reg[C_TXPL] | cmd_reg[C_NOACK] | cmd_reg[C_ACK]) && accept_reg && idx_reg != 6'h00)
            begin
              tx_commit_o <= 1'b1; // RULE9
              tx_commit_len_o <= idx_reg;
              tx_commit_pipe_o <= pipe_reg; // RULE16
              tx_commit_kind_o <= cmd_reg[C_ACK] ? `RFCMD_KIND_ACK
                : (cmd_reg[C_NOACK] ? `RFCMD_KIND_UNACKED : `RFCMD_KIND_NORMAL); // RULE18
            end
          end
          else if (byte_valid)
          begin
            // Bytes past the documented maximum are dropped
            if (idx_reg != `RFCMD_PL_MAX_BYTES)
              idx_reg <= idx_reg + 6'h01;
            if (cmd_reg[C_WREG] && accept_reg && idx_reg < `RFCMD_REG_MAX_BYTES)
            begin
              reg_wr_o <= 1'b1; // RULE7
              reg_wr_data_o <= rx_byte;
            end
            if ((cmd_reg[C_TXPL] | cmd_reg[C_NOACK] | cmd_reg[C_ACK]) && accept_reg
                && idx_reg < `RFCMD_PL_MAX_BYTES)
            begin
              tx_wr_o <= 1'b1; // RULE9
              tx_wr_index_o <= idx_reg[4:0];
              tx_wr_data_o <= rx_byte;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // rfcmd_core

// *** hw/rfcmd_defs.vh ***
// Command codes, field positions and limits of the radio command interpreter
`ifndef RFCMD_DEFS_VH
`define RFCMD_DEFS_VH

// ----------------------------------------------------------------------------
// Radio control register location of the command select bit
// ----------------------------------------------------------------------------
`define RFCMD_RADIO_CONTROL_ADDR 8'hE8
`define RFCMD_RADIO_CONTROL_CSN_BIT 1

// ----------------------------------------------------------------------------
// Command words
// ----------------------------------------------------------------------------
`define RFCMD_RD_REG_PFX 3'h0
`define RFCMD_WR_REG_PFX 3'h1
`define RFCMD_RD_RX_PL 8'h61
`define RFCMD_WR_TX_PL 8'hA0
`define RFCMD_FLUSH_TX 8'hE1
`define RFCMD_FLUSH_RX 8'hE2
`define RFCMD_REPEAT_LAST 8'hE3
`define RFCMD_RD_HEAD_WIDTH 8'h60
`define RFCMD_WR_ACK_PFX 5'h15
`define RFCMD_WR_UNACKED 8'hB0
`define RFCMD_IDLE 8'hFF

// ----------------------------------------------------------------------------
// Limits and commit kinds
// ----------------------------------------------------------------------------
`define RFCMD_REG_MAX_BYTES 6'h05
`define RFCMD_PL_MAX_BYTES 6'h20
`define RFCMD_ACK_MAX_PENDING 2'h3
`define RFCMD_ACK_PIPE_MAX 3'h5
`define RFCMD_KIND_NORMAL 2'h0
`define RFCMD_KIND_UNACKED 2'h1
`define RFCMD_KIND_ACK 2'h2

`endif

// *** hw/rfcmd_shifter.v ***
// Serial byte shifter of the radio command port, sampled in the system clock
module rfcmd_shifter (
  input wire clk_i,
  input wire resetn_i,
  input wire sck_i,
  input wire mosi_i,
  input wire csn_n_i,
  input wire [7:0] status_i,
  input wire [7:0] tx_byte_i,
  output reg frame_start_o,
  output reg frame_end_o,
  output reg byte_valid_o,
  output reg [7:0] rx_byte_o,
  output wire miso_o
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  reg [2:0] meta_reg;
  reg [2:0] sync_reg;
  reg sck_d_reg;
  reg csn_d_reg;
  reg [7:0] in_shift_reg;
  reg [7:0] out_shift_reg;
  reg [2:0] bit_cnt_reg;
  wire sck_s;
  wire mosi_s;
  wire csn_s;
  wire sck_rise;
  wire sck_fall;

  assign sck_s = sync_reg[2];
  assign mosi_s = sync_reg[1];
  assign csn_s = sync_reg[0];
  assign sck_rise = sck_s & ~sck_d_reg & ~csn_s;
  assign sck_fall = ~sck_s & sck_d_reg & ~csn_s;
  assign miso_o = out_shift_reg[7]; // RULE4

  // Two stages; only the second stage feeds edge detection
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      meta_reg <= 3'h1;
      sync_reg <= 3'h1;
    end
    else
    begin
      meta_reg <= {sck_i, mosi_i, csn_n_i};
      sync_reg <= meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Shifting, mode 0: sample on rising, change on falling edge
  // --------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      sck_d_reg <= 1'b0;
      csn_d_reg <= 1'b1;
      in_shift_reg <= 8'h00;
      out_shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      frame_start_o <= 1'b0;
      frame_end_o <= 1'b0;
      byte_valid_o <= 1'b0;
      rx_byte_o <= 8'h00;
    end
    else
    begin
      sck_d_reg <= sck_s;
      csn_d_reg <= csn_s;
      frame_start_o <= csn_d_reg & ~csn_s; // RULE1
      frame_end_o <= ~csn_d_reg & csn_s; // RULE21
      byte_valid_o <= 1'b0;
      if (csn_d_reg & ~csn_s)
      begin
        // Status goes out under the command byte
        out_shift_reg <= status_i; // RULE3
        bit_cnt_reg <= 3'h0;
      end
      else if (csn_s)
        bit_cnt_reg <= 3'h0; // Partial byte dropped at frame end
      else if (sck_rise)
      begin
        in_shift_reg <= {in_shift_reg[6:0], mosi_s}; // RULE4
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7)
        begin
          byte_valid_o <= 1'b1;
          rx_byte_o <= {in_shift_reg[6:0], mosi_s};
        end
      end
      else if (sck_fall)
      begin
        // Next byte loaded at the first falling edge after a whole byte
        if (bit_cnt_reg == 3'h0)
          out_shift_reg <= tx_byte_i; // RULE5
        else
          out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      end
    end
  end

endmodule // rfcmd_shifter

// *** verification/rfcmd_core_sva.sv ***
// Checker of the radio command interpreter outputs
`include "rfcmd_defs.vh"
module rfcmd_core_sva (
  input wire clk_i,
  input wire resetn_i,
  input wire radio_control_csn_n_i,
  input wire ack_sent_i,
  input wire reg_wr_o,
  input wire rx_pop_o,
  input wire rx_flush_o,
  input wire tx_wr_o,
  input wire tx_commit_o,
  input wire [1:0] tx_commit_kind_o,
  input wire [2:0] tx_commit_pipe_o,
  input wire [5:0] tx_commit_len_o,
  input wire tx_flush_o,
  input wire tx_reuse_o,
  input wire [1:0] ack_pending_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Ack commit adds one entry
  property p_ack_add;
    tx_commit_o && tx_commit_kind_o == `RFCMD_KIND_ACK && !ack_sent_i |=> ack_pending_o == $past(ack_pending_o) + 2'h1;
  endproperty
  a_ack_add: assert property (p_ack_add) else $error("ack count not raised");
  // Sent ack frees one entry
  property p_ack_sub;
    ack_sent_i && !tx_commit_o && ack_pending_o != 2'h0 |=> ack_pending_o == $past(ack_pending_o) - 2'h1;
  endproperty
  a_ack_sub: assert property (p_ack_sub) else $error("ack count not lowered");
  // Pipe index must stay legal
  property p_ack_pipe;
    tx_commit_o && tx_commit_kind_o == `RFCMD_KIND_ACK |-> tx_commit_pipe_o <= 3'h5;
  endproperty
  a_ack_pipe: assert property (p_ack_pipe) else $error("illegal ack pipe");
  // Committed lengths within one to 32
  property p_len;
    tx_commit_o |-> tx_commit_len_o >= 6'h01 && tx_commit_len_o <= 6'h20;
  endproperty
  a_len: assert property (p_len) else $error("bad commit length");
  // Flush ends payload repeat
  property p_reuse_end;
    tx_flush_o |-> ##[0:1] !tx_reuse_o;
  endproperty
  a_reuse_end: assert property (p_reuse_end) else $error("repeat kept after flush");
  // One write per byte, bytes are far apart
  property p_tx_gap;
    tx_wr_o |=> !tx_wr_o [*8];
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("payload writes too close");
  property p_reg_gap;
    reg_wr_o |=> !reg_wr_o [*8];
  endproperty
  a_reg_gap: assert property (p_reg_gap) else $error("register writes too close");
  // Commit and pop wait for the frame to close
  property p_commit_end;
    tx_commit_o |-> $past(radio_control_csn_n_i, 3);
  endproperty
  a_commit_end: assert property (p_commit_end) else $error("commit inside frame");
  property p_pop_end;
    rx_pop_o |-> $past(radio_control_csn_n_i, 3) && !rx_flush_o;
  endproperty
  a_pop_end: assert property (p_pop_end) else $error("pop inside frame");
  // Flushes come from a command byte inside a frame
  property p_flush;
    rx_flush_o || tx_flush_o |-> !$past(radio_control_csn_n_i, 6);
  endproperty
  a_flush: assert property (p_flush) else $error("flush outside frame");
endmodule // rfcmd_core_sva

bind rfcmd_core rfcmd_core_sva i_rfcmd_core_sva (
  .clk_i(clk_i), .resetn_i(resetn_i), .radio_control_csn_n_i(radio_control_csn_n_i),
  .ack_sent_i(ack_sent_i), .reg_wr_o(reg_wr_o), .rx_pop_o(rx_pop_o), .rx_flush_o(rx_flush_o),
  .tx_wr_o(tx_wr_o), .tx_commit_o(tx_commit_o), .tx_commit_kind_o(tx_commit_kind_o),
  .tx_commit_pipe_o(tx_commit_pipe_o), .tx_commit_len_o(tx_commit_len_o), .tx_flush_o(tx_flush_o),
  .tx_reuse_o(tx_reuse_o), .ack_pending_o(ack_pending_o)
);

// *** verification/rfcmd_core_tb.sv ***
// Self-checking bench of the radio command interpreter
module rfcmd_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] cmd; logic [5:0] n; logic [5:0] wr; logic [3:0] ev; logic [1:0] kind;
    logic [7:0] d;} rfcmd_row_t;
  // ----
  // Signals and models
  // ----
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] status = 8'h00;
  logic standby = 1'b1;
  logic tx_full = 1'b0;
  logic ack_sent = 1'b0;
  logic clr = 1'b0;
  logic [5:0] wr_n = 6'h00;
  logic [3:0] ev = 4'h0;
  logic [7:0] got [0:32];
  int error_cnt = 0;
  int compares = 0;
  wire sck, mosi, csn_n, miso, reg_wr, rx_pop, rx_flush, tx_wr, tx_commit, tx_flush, tx_reuse;
  wire [4:0] reg_index, rx_rd_index, tx_wr_index;
  wire [2:0] reg_byte, commit_pipe;
  wire [7:0] reg_wr_data, tx_wr_data, reg_rd, rx_rd;
  wire [5:0] commit_len;
  wire [1:0] commit_kind, ack_pending;
  rfcmd_row_t rows [0:8] = '{
    '{8'hA0, 6'h04, 6'h04, 4'h8, 2'h0, 8'h33}, '{8'hB0, 6'h02, 6'h02, 4'h8, 2'h1, 8'h31},
    '{8'hAA, 6'h01, 6'h01, 4'h8, 2'h2, 8'h30}, '{8'h25, 6'h03, 6'h03, 4'h0, 2'h0, 8'h32},
    '{8'h03, 6'h02, 6'h00, 4'h0, 2'h0, 8'hA2}, '{8'h61, 6'h03, 6'h00, 4'h4, 2'h0, 8'h42},
    '{8'h60, 6'h01, 6'h00, 4'h0, 2'h0, 8'h1B}, '{8'hA0, 6'h21, 6'h20, 4'h8, 2'h0, 8'h4F},
    '{8'hE1, 6'h00, 6'h00, 4'h2, 2'h0, 8'h00}};
  // Register file and receive store answer at once
  assign reg_rd = {3'h5, reg_index} ^ {5'h00, reg_byte};
  assign rx_rd = {3'h2, rx_rd_index};
  always #50 clk_i = ~clk_i;
  // Pulse collector, cleared before each frame
  always @(posedge clk_i)
  begin
    wr_n <= clr ? 6'h00 : wr_n + 6'(reg_wr) + 6'(tx_wr);
    ev <= clr ? 4'h0 : ev | {tx_commit, rx_pop, tx_flush, rx_flush};
  end
  rfcmd_spi_master i_rfcmd_spi_master (.clk_i(clk_i), .miso_i(miso), .sck_o(sck), .mosi_o(mosi), .csn_n_o(csn_n));
  rfcmd_core i_rfcmd_core (.clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .mosi_i(mosi),
    .radio_control_csn_n_i(csn_n), .miso_o(miso), .status_i(status), .standby_i(standby), .tx_full_i(tx_full),
    .reg_rd_data_i(reg_rd), .rx_rd_data_i(rx_rd), .rx_head_width_i(6'h1B), .ack_sent_i(ack_sent),
    .reg_index_o(reg_index), .reg_byte_o(reg_byte), .reg_wr_o(reg_wr), .reg_wr_data_o(reg_wr_data),
    .rx_rd_index_o(rx_rd_index), .rx_pop_o(rx_pop), .rx_flush_o(rx_flush), .tx_wr_o(tx_wr),
    .tx_wr_index_o(tx_wr_index), .tx_wr_data_o(tx_wr_data), .tx_commit_o(tx_commit),
    .tx_commit_kind_o(commit_kind), .tx_commit_pipe_o(commit_pipe), .tx_commit_len_o(commit_len),
    .tx_flush_o(tx_flush), .tx_reuse_o(tx_reuse), .ack_pending_o(ack_pending));
  // ----
  // Tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Data bytes count up from 0x30, index 0 first
  task automatic frame(input logic [7:0] cmd, input int n);
    logic [7:0] st;
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    i_rfcmd_spi_master.open_frame();
    i_rfcmd_spi_master.xfer(cmd, st);
    check(st, status);
    for (int k = 0; k < n; k++)
      i_rfcmd_spi_master.xfer(8'h30 + 8'(k), got[k]);
    i_rfcmd_spi_master.close_frame();
    repeat (10) @(posedge clk_i);
  endtask
  task automatic end_sim();
    $display("compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the expected 0.76 ms run
  initial
  begin
    #5ms;
    error_cnt++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_sim();
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rows[r])
    begin
      status <= {4'hC, 4'(r)};
      frame(rows[r].cmd, int'(rows[r].n));
      check(8'(wr_n), 8'(rows[r].wr));
      check(8'(ev), 8'(rows[r].ev));
      if (rows[r].ev[3])
        check({commit_kind, commit_len}, {rows[r].kind, rows[r].wr});
      if (rows[r].ev[3])
        check(8'(commit_pipe), 8'(rows[r].cmd[2:0]));
      if (rows[r].cmd[7:5] == 3'h5)
      begin
        check(tx_wr_data, rows[r].d);
        check(8'(tx_wr_index), 8'(rows[r].wr - 6'h01));
      end
      else if (rows[r].cmd[7:5] == 3'h1)
      begin
        check(reg_wr_data, rows[r].d);
        check(8'(reg_index), 8'(rows[r].cmd[4:0]));
      end
      else if (rows[r].n != 6'h00)
        check(got[rows[r].n - 6'h01], rows[r].d);
      $display("row %0d done", r);
    end
    frame(8'hE2, 0);
    check(8'(ev), 8'h01);
    frame(8'hFF, 0);
    check({8'(wr_n) | 8'(ev)}, 8'h00);
    frame(8'hE3, 0);
    check(8'(tx_reuse), 8'h01);
    frame(8'hA0, 1);
    check(8'(tx_reuse), 8'h00);
    $display("repeat test done");
    frame(8'hA8, 1);
    frame(8'hAD, 1);
    frame(8'hA9, 1);
    check(8'(ack_pending), 8'h03);
    @(posedge clk_i);
    ack_sent <= 1'b1;
    @(posedge clk_i);
    ack_sent <= 1'b0;
    frame(8'hAE, 1);
    check({8'(ack_pending) | 8'(ev)}, 8'h02);
    tx_full <= 1'b1;
    frame(8'hA0, 1);
    check(8'(ev), 8'h00);
    tx_full <= 1'b0;
    standby <= 1'b0;
    frame(8'h25, 1);
    check(8'(wr_n), 8'h00);
    $display("refusal test done");
    frame(8'hE3, 0);
    check(8'(tx_reuse), 8'h01);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({6'h00, tx_reuse, ack_pending != 2'h0}, 8'h00);
    resetn_i <= 1'b1;
    // A full frame after the second release proves the port works again
    frame(8'h60, 1);
    check(got[0], 8'h1B);
    $display("reset test done");
    end_sim();
  end
endmodule // rfcmd_core_tb

// *** verification/rfcmd_spi_master.sv ***
// Behavioural controller framing commands on the serial port
module rfcmd_spi_master (
  input wire clk_i,
  input wire miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic csn_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Frame tasks, sck high for 5 clocks, low for 6
  // ----
  initial
  begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    csn_n_o = 1'b1;
  end
  // Wait out the select synchroniser before shifting
  task automatic open_frame();
    @(posedge clk_i);
    csn_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // One byte, MSB first, miso read before each rising sck
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk_i);
      mosi_o <= tx[i];
      repeat (5) @(posedge clk_i);
      rx[i] = miso_i;
      sck_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      sck_o <= 1'b0;
    end
  endtask
  // Released data line flips so a stale bit is never seen
  task automatic close_frame();
    repeat (5) @(posedge clk_i);
    csn_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // rfcmd_spi_master
